// ### rtl/pmcs_pkg.sv
// Package for the power mode and clock select block
package pmcs_pkg;

  // ----------------------------------------------------------------
  // Register indices on the plain register port
  // ----------------------------------------------------------------
  localparam logic [2:0] PMCS_OSC_CTRL_ADDR   = 3'h0;
  localparam logic [2:0] PMCS_OSC_CTRL2_ADDR  = 3'h1;
  localparam logic [2:0] PMCS_OSC_TUNE_ADDR   = 3'h2;
  localparam logic [2:0] PMCS_IRQ_PRIO2_ADDR  = 3'h3;
  localparam logic [2:0] PMCS_IRQ_EN2_ADDR    = 3'h4;
  localparam logic [2:0] PMCS_IRQ_FLAG2_ADDR  = 3'h5;
  localparam logic [2:0] PMCS_CLK_CFG_ADDR    = 3'h6;
  localparam logic [2:0] PMCS_IRQ_MASK_ADDR   = 3'h7;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PMCS_GATE_BIT     = 7;
  localparam int PMCS_DONE_BIT     = 3;
  localparam int PMCS_SEL_LSB      = 0;
  localparam int PMCS_SECONDARY_RUN_MODE_BIT  = 6;
  localparam int PMCS_FAIL_BIT     = 7;
  localparam int PMCS_TWO_SPEED_STARTUP_ENABLE_BIT     = 7;
  localparam int PMCS_FAIL_MONITOR_ENABLE_BIT    = 6;
  localparam int PMCS_EVT_FAIL     = 0;
  localparam int PMCS_EVT_DONE     = 1;
  localparam int PMCS_EVT_WAKE     = 2;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] PMCS_OSC_CTRL_RST  = 8'h00;
  localparam logic [7:0] PMCS_BYTE_RST      = 8'h00;
  localparam int         PMCS_OST_COUNT     = 1024;
  localparam logic [10:0] PMCS_OST_LAST     = 11'h3FF;

  // Primary oscillator configuration codes
  localparam logic [3:0] PMCS_CFG_LP  = 4'h0;
  localparam logic [3:0] PMCS_CFG_XT  = 4'h1;
  localparam logic [3:0] PMCS_CFG_HS  = 4'h2;

  typedef enum logic [1:0] {
    PMCS_SRC_PRI,
    PMCS_SRC_SEC,
    PMCS_SRC_INT,
    PMCS_SRC_NONE
  } pmcs_src_t;

  typedef enum {
    PMCS_RUN,
    PMCS_IDLE,
    PMCS_SLEEP
  } pmcs_mode_t;

endpackage : pmcs_pkg

// ### rtl/pmcs_top.sv
// Power mode, clock source selection and fail monitor gating
//
// Overview of operation
// - Fail monitor enabled only after start timer expiry or skip
// - Start timer runs after wake from sleep and reset
// - External clock or RC mode skips start timer
// - Fail monitor inactive during oscillator start-up
// - Bit 7 gates CPU, bits 1:0 select source
// - Source switch immediate if ready, else delayed
// - Sleep instruction alone enters idle or sleep
// - Gate bit 0 at sleep stops all clocks
// - Run modes: 00 primary, 01 secondary, 1x internal
// - Gate bit 1 at sleep clocks peripherals only
// - Internal block: fast, postscaled, slow oscillators
// - Seven modes: three run, three idle, sleep
// - Any reset clears clock source select field
// - Start timer counts 1024 oscillations then flags done
// - Clock failure forces internal source, sets fail flag
`timescale 1ns/1ps
`default_nettype none

module pmcs_top
  import pmcs_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // Register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata,
  // Core and configuration
  input  wire logic       sleep_instr,
  input  wire logic       wake_event,
  input  wire logic [7:0] clock_configuration_high,
  // Oscillator status pins
  input  wire logic       primary_osc_tick,
  input  wire logic       secondary_ready,
  input  wire logic       fast_internal_ready,
  input  wire logic       slow_internal_ready,
  input  wire logic       clock_fail_detect,
  // Clock gate controls
  output var  logic [1:0] sys_clk_source,
  output var  logic       cpu_clk_en,
  output var  logic       periph_clk_en,
  output var  logic       clock_fail_monitor,
  output var  logic       irq
);
  import pmcs_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pin_meta_reg;
  logic [4:0] pin_sync_reg;
  logic       tick_prev_reg;
  wire  [4:0] pin_raw = {clock_fail_detect, slow_internal_ready,
                         fast_internal_ready, secondary_ready,
                         primary_osc_tick};

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pin_meta_reg  <= 5'h00;
      pin_sync_reg  <= 5'h00;
      tick_prev_reg <= 1'b0;
    end else begin
      pin_meta_reg  <= pin_raw;
      pin_sync_reg  <= pin_meta_reg;
      tick_prev_reg <= pin_sync_reg[0];
    end
  end

  wire osc_edge   = pin_sync_reg[0] & ~tick_prev_reg;
  wire sec_ok     = pin_sync_reg[1];
  // Internal block counts as ready from either the fast oscillator
  // (direct or postscaled) or the slow one
  wire int_ok     = pin_sync_reg[2] | pin_sync_reg[3];
  wire fail_pin   = pin_sync_reg[4];

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic       gate_reg;
  logic [1:0] sel_reg;
  logic [2:0] ctrl_mid_reg;
  logic [7:0] tune_reg;
  logic [7:0] prio2_reg;
  logic [7:0] en2_reg;
  logic [7:0] flag2_reg;
  logic [2:0] evt_reg;
  logic [2:0] mask_reg;
  logic       done_reg;
  logic       fail_state_reg;
  logic [10:0] ost_cnt_reg;
  logic       ost_run_reg;
  pmcs_mode_t mode_reg;
  logic [1:0] src_reg;

  wire [3:0] pri_cfg     = clock_configuration_high[3:0];
  wire       fcm_enable  = clock_configuration_high[PMCS_FAIL_MONITOR_ENABLE_BIT];
  wire       two_speed   = clock_configuration_high[PMCS_TWO_SPEED_STARTUP_ENABLE_BIT];
  // Only crystal modes need the start timer
  wire       is_crystal  = (pri_cfg == PMCS_CFG_LP) |
                           (pri_cfg == PMCS_CFG_XT) |
                           (pri_cfg == PMCS_CFG_HS);

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire wr_ctrl  = reg_wr && (reg_addr == PMCS_OSC_CTRL_ADDR);
  wire wr_tune  = reg_wr && (reg_addr == PMCS_OSC_TUNE_ADDR);
  wire wr_prio  = reg_wr && (reg_addr == PMCS_IRQ_PRIO2_ADDR);
  wire wr_en    = reg_wr && (reg_addr == PMCS_IRQ_EN2_ADDR);
  wire wr_flag  = reg_wr && (reg_addr == PMCS_IRQ_FLAG2_ADDR);
  wire wr_mask  = reg_wr && (reg_addr == PMCS_IRQ_MASK_ADDR);
  wire rd_flag2 = reg_rd && (reg_addr == PMCS_OSC_CTRL2_ADDR);

  // Toggling the internal-select bit restarts the timer
  wire sel1_toggle = wr_ctrl && (reg_wdata[1] != sel_reg[1]);

  // ----------------------------------------------------------------
  // Mode control
  // ----------------------------------------------------------------
  wire in_sleep   = (mode_reg == PMCS_SLEEP);
  wire wake_now   = in_sleep && wake_event;
  // Timer start on reset release is covered by the reset value
  wire ost_start  = wake_now | sel1_toggle;
  wire fail_evt   = fcm_enable && clock_fail_monitor && fail_pin &&
                    !fail_state_reg;
  wire ost_expire = ost_run_reg && osc_edge &&
                    (ost_cnt_reg == PMCS_OST_LAST);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mode_reg <= PMCS_RUN;
    end else if (sleep_instr && !in_sleep) begin
      // Gate bit sampled at the instruction itself
      mode_reg <= gate_reg ? PMCS_IDLE : PMCS_SLEEP;
    end else if (wake_event) begin
      mode_reg <= PMCS_RUN;
    end
  end

  // ----------------------------------------------------------------
  // Start timer; a sleep aborts a count in progress
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ost_run_reg <= 1'b1;
      ost_cnt_reg <= 11'h000;
      done_reg    <= 1'b0;
    end else if (sleep_instr && !in_sleep) begin
      ost_run_reg <= 1'b0;
      done_reg    <= 1'b0;
    end else if (ost_start) begin
      ost_run_reg <= 1'b1;
      ost_cnt_reg <= 11'h000;
      done_reg    <= 1'b0;
    end else if (ost_run_reg && !is_crystal) begin
      ost_run_reg <= 1'b0;
      done_reg    <= 1'b1;
    end else if (ost_expire) begin
      ost_run_reg <= 1'b0;
      done_reg    <= 1'b1;
    end else if (ost_run_reg && osc_edge) begin
      ost_cnt_reg <= ost_cnt_reg + 11'h001;
    end
  end

  // ----------------------------------------------------------------
  // Fail-safe condition: held until reset or timer restart ends
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fail_state_reg     <= 1'b0;
      clock_fail_monitor <= 1'b0;
    end else begin
      if (fail_evt) begin
        fail_state_reg <= 1'b1;
      end else if (ost_expire || (ost_run_reg && !is_crystal)) begin
        fail_state_reg <= 1'b0;
      end
      // Never armed while the start timer counts
      // Drops with the peripheral clock at sleep entry, not a cycle late
      clock_fail_monitor <= fcm_enable && done_reg && !ost_run_reg &&
                            !ost_start && !in_sleep &&
                            !(sleep_instr && !gate_reg);
    end
  end

  // ----------------------------------------------------------------
  // Clock source selection and gating
  // ----------------------------------------------------------------
  logic [1:0] src_next;
  wire  [1:0] want_src = sel_reg[1] ? PMCS_SRC_INT :
                         (sel_reg[0] ? PMCS_SRC_SEC : PMCS_SRC_PRI);
  wire  pri_ok   = done_reg && !fail_state_reg;
  wire  want_ok  = (want_src == PMCS_SRC_INT) ? int_ok :
                   (want_src == PMCS_SRC_SEC) ? sec_ok : pri_ok;
  // Two-speed start runs from internal while the timer counts
  wire  use_int  = fail_state_reg ||
                   (two_speed && want_src == PMCS_SRC_PRI && !pri_ok);

  always_comb begin
    src_next = src_reg;
    if (in_sleep) begin
      src_next = PMCS_SRC_NONE;
    end else if (use_int) begin
      src_next = PMCS_SRC_INT;
    end else if (want_ok) begin
      src_next = want_src;
    end else if (src_reg == PMCS_SRC_NONE) begin
      src_next = want_src;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      src_reg        <= PMCS_SRC_PRI;
      sys_clk_source <= PMCS_SRC_PRI;
      cpu_clk_en     <= 1'b1;
      periph_clk_en  <= 1'b1;
    end else begin
      src_reg        <= src_next;
      sys_clk_source <= src_next;
      // Three run, three idle, one sleep mode
      cpu_clk_en     <= (mode_reg == PMCS_RUN) &&
                        !(sleep_instr && !in_sleep);
      periph_clk_en  <= !in_sleep &&
                        !(sleep_instr && !gate_reg);
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gate_reg     <= PMCS_OSC_CTRL_RST[PMCS_GATE_BIT];
      sel_reg      <= PMCS_OSC_CTRL_RST[1:0];
      ctrl_mid_reg <= PMCS_OSC_CTRL_RST[6:4];
      tune_reg     <= PMCS_BYTE_RST;
      prio2_reg    <= PMCS_BYTE_RST;
      en2_reg      <= PMCS_BYTE_RST;
      mask_reg     <= 3'h0;
    end else begin
      if (wr_ctrl) begin
        gate_reg     <= reg_wdata[PMCS_GATE_BIT];
        sel_reg      <= reg_wdata[PMCS_SEL_LSB +: 2];
        ctrl_mid_reg <= reg_wdata[6:4];
      end
      if (wr_tune) tune_reg  <= reg_wdata;
      if (wr_prio) prio2_reg <= reg_wdata;
      if (wr_en)   en2_reg   <= reg_wdata;
      if (wr_mask) mask_reg  <= reg_wdata[2:0];
    end
  end

  // Flag register: hardware set wins over software write
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flag2_reg <= PMCS_BYTE_RST;
    end else begin
      if (wr_flag) flag2_reg <= reg_wdata;
      if (fail_evt) flag2_reg[PMCS_FAIL_BIT] <= 1'b1;
    end
  end

  // Event status, cleared by reading it; new events win
  wire [2:0] evt_in = {wake_now, ost_expire, fail_evt};
  wire rd_evt = reg_rd && (reg_addr == PMCS_OSC_CTRL2_ADDR);
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      evt_reg <= 3'h0;
    end else begin
      evt_reg <= (rd_evt ? 3'h0 : evt_reg) | evt_in;
    end
  end

  // ----------------------------------------------------------------
  // Read data and interrupt
  // ----------------------------------------------------------------
  wire [7:0] ctrl_rd  = {gate_reg, ctrl_mid_reg, done_reg,
                         int_ok, sel_reg};
  wire [7:0] ctrl2_rd = {1'b0, (src_reg == PMCS_SRC_SEC), 3'h0,
                         evt_reg};
  logic [7:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      PMCS_OSC_CTRL_ADDR:  rd_mux = ctrl_rd;
      PMCS_OSC_CTRL2_ADDR: rd_mux = ctrl2_rd;
      PMCS_OSC_TUNE_ADDR:  rd_mux = tune_reg;
      PMCS_IRQ_PRIO2_ADDR: rd_mux = prio2_reg;
      PMCS_IRQ_EN2_ADDR:   rd_mux = en2_reg;
      PMCS_IRQ_FLAG2_ADDR: rd_mux = flag2_reg;
      PMCS_CLK_CFG_ADDR:   rd_mux = clock_configuration_high;
      PMCS_IRQ_MASK_ADDR:  rd_mux = {5'h00, mask_reg};
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
      irq       <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
      irq       <= |(evt_reg & mask_reg) ||
                   (flag2_reg[PMCS_FAIL_BIT] && en2_reg[PMCS_FAIL_BIT]);
    end
  end

  wire unused_ok = rd_flag2;

endmodule : pmcs_top

`default_nettype wire

// ### test/pmcs_assertions.sv
// Assertion checker for the power mode and clock select block
`timescale 1ns/1ps
`default_nettype none
module pmcs_chk
  import pmcs_pkg::*;
(
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       nrst,
  // Observed ports
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       sleep_instr,
  input wire logic [7:0] clock_configuration_high,
  input wire logic       clock_fail_detect,
  input wire logic [1:0] sys_clk_source,
  input wire logic       cpu_clk_en,
  input wire logic       periph_clk_en,
  input wire logic       clock_fail_monitor
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  AST_SLEEP_OFF: assert property (
    sys_clk_source == 2'h3 |-> !cpu_clk_en && !periph_clk_en)
    else $error("clocks run in sleep");
  AST_IDLE_SRC: assert property (
    !cpu_clk_en && periph_clk_en |-> sys_clk_source != 2'h3)
    else $error("idle without source");
  AST_RUN_BOTH: assert property (cpu_clk_en |-> periph_clk_en)
    else $error("cpu clocked without peripherals");
  AST_RUN_SRC: assert property (cpu_clk_en |-> sys_clk_source != 2'h3)
    else $error("run mode without source");
  AST_MON_GATE: assert property (
    clock_fail_monitor |-> periph_clk_en && clock_configuration_high[6])
    else $error("monitor armed when not allowed");
  AST_ENTRY_CAUSE: assert property (
    $fell(cpu_clk_en) |-> $past(sleep_instr))
    else $error("cpu stopped without sleep instruction");
  AST_ENTRY_NEXT: assert property (
    sleep_instr && cpu_clk_en |=> !cpu_clk_en)
    else $error("sleep instruction ignored");
  AST_WAKE_OST: assert property (
    $rose(periph_clk_en) && clock_configuration_high[3:0] <= PMCS_CFG_HS
    |-> !clock_fail_monitor [*8])
    else $error("monitor armed during start-up");
  AST_FAIL_INT: assert property (
    $rose(clock_fail_detect) && clock_fail_monitor
    |-> ##[1:8] sys_clk_source == 2'h2)
    else $error("failure did not force internal source");
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
endmodule : pmcs_chk
`default_nettype wire

// ### test/pmcs_osc_model.sv
// Behavioural model of the oscillators beside the block
`timescale 1ns/1ps
`default_nettype none
module pmcs_osc_model (
  // Test control
  input  wire logic fail_req,
  // Oscillator pins
  output var  logic primary_osc_tick,
  output var  logic secondary_ready,
  output var  logic fast_internal_ready,
  output var  logic slow_internal_ready,
  output wire logic clock_fail_detect
);
  // Crystal period 220 ns: no phase relation to the core clock, and
  // each half period outlasts one core cycle so no edge is lost
  initial begin
    primary_osc_tick    = 1'b0;
    secondary_ready     = 1'b1;
    fast_internal_ready = 1'b1;
    slow_internal_ready = 1'b1;
    forever #110 primary_osc_tick = ~primary_osc_tick & ~fail_req;
  end
  // The detector reports 7 ns after the request, before a failed crystal stops ticking
  assign #7 clock_fail_detect = fail_req;
endmodule : pmcs_osc_model
`default_nettype wire

// ### test/tb.sv
// Self-checking testbench for the power mode and clock select block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pmcs_pkg::*;
  logic       core_clk  = 1'b0;
  logic       nrst      = 1'b0;
  logic [2:0] reg_addr  = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic       sleep_instr = 1'b0;
  logic       wake_event  = 1'b0;
  logic [7:0] cfg       = 8'hC0;
  logic       fail_req  = 1'b0;
  logic [7:0] rv;
  int         err_total = 0;
  int         n_tests   = 0;
  wire  [7:0] reg_rdata;
  wire  [1:0] src;
  wire        cpu_en, per_en, mon, irq, tick, sec_r, fast_r, slow_r, fdet;

  pmcs_osc_model u_osc (.fail_req(fail_req), .primary_osc_tick(tick),
    .secondary_ready(sec_r), .fast_internal_ready(fast_r),
    .slow_internal_ready(slow_r), .clock_fail_detect(fdet));
  pmcs_top DUT (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sleep_instr(sleep_instr),
    .wake_event(wake_event), .clock_configuration_high(cfg),
    .primary_osc_tick(tick), .secondary_ready(sec_r),
    .fast_internal_ready(fast_r), .slow_internal_ready(slow_r),
    .clock_fail_detect(fdet), .sys_clk_source(src), .cpu_clk_en(cpu_en),
    .periph_clk_en(per_en), .clock_fail_monitor(mon), .irq(irq));

  initial begin
    forever #50 core_clk = ~core_clk;
  end

  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic cyc(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(logic [2:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 rv = reg_rdata;
  endtask : rd

  task automatic pulse(bit wake);
    @(posedge core_clk);
    if (wake) wake_event <= 1'b1;
    else sleep_instr <= 1'b1;
    @(posedge core_clk);
    wake_event  <= 1'b0;
    sleep_instr <= 1'b0;
    // Mode and entry gating land on the first edge; the source select and wake-up enables on the next
    cyc(1);
  endtask : pulse

  // Bounded wait; the caller judges the outcome
  task automatic wait_for(bit on_mon, logic [1:0] s, int lim);
    for (int i = 0; i < lim; i++) begin
      if (on_mon ? mon === 1'b1 : src === s) break;
      cyc(1);
    end
  endtask : wait_for

  function automatic logic [7:0] clk_state();
    return {4'h0, cpu_en, per_en, src};
  endfunction : clk_state

  task automatic t_reset;
    rd(PMCS_OSC_CTRL_ADDR);
    check("ctrl", rv & 8'h8B, PMCS_OSC_CTRL_RST);
    check("state", clk_state(), 8'h0E);
    check("mon", {7'h0, mon}, 8'h00);
    wr(PMCS_CLK_CFG_ADDR, 8'hFF);
    rd(PMCS_CLK_CFG_ADDR);
    check("config", rv, cfg);
  endtask : t_reset

  task automatic t_start(int early);
    cyc(early);
    check("early mon", {7'h0, mon}, 8'h00);
    rd(PMCS_OSC_CTRL_ADDR);
    check("early done", rv & 8'h08, 8'h00);
    wait_for(1'b1, 2'h0, 400);
    check("mon", {7'h0, mon}, 8'h01);
    rd(PMCS_OSC_CTRL_ADDR);
    check("done", rv & 8'h08, 8'h08);
  endtask : t_start

  task automatic t_src;
    logic [1:0] e;
    for (int s = 0; s < 4; s++) begin
      e = s[1] ? 2'h2 : 2'(s);
      wr(PMCS_OSC_CTRL_ADDR, 8'(s));
      wait_for(1'b0, e, 10);
      check("src", {6'h0, src}, {6'h0, e});
      rd(PMCS_OSC_CTRL_ADDR);
      check("sel", rv & 8'h83, 8'(s));
    end
  endtask : t_src

  task automatic t_modes;
    wr(PMCS_OSC_CTRL_ADDR, 8'h81);
    pulse(1'b0);
    check("idle", clk_state(), 8'h05);
    wr(PMCS_OSC_CTRL_ADDR, 8'h01);
    check("late gate", clk_state(), 8'h05);
    pulse(1'b1);
    check("run", clk_state(), 8'h0D);
    pulse(1'b0);
    check("sleep", clk_state(), 8'h03);
    pulse(1'b1);
    check("wake", clk_state(), 8'h0D);
    check("wake mon", {7'h0, mon}, 8'h00);
    check("masked", {7'h0, irq}, 8'h00);
    wr(PMCS_IRQ_MASK_ADDR, 8'h04);
    cyc(2);
    check("irq", {7'h0, irq}, 8'h01);
    rd(PMCS_OSC_CTRL2_ADDR);
    check("wake evt", rv & 8'h04, 8'h04);
    cyc(2);
    check("cleared", {7'h0, irq}, 8'h00);
    wr(PMCS_IRQ_MASK_ADDR, 8'h00);
  endtask : t_modes

  task automatic t_fail;
    wait_for(1'b1, 2'h0, 2600);
    check("armed", {7'h0, mon}, 8'h01);
    wr(PMCS_IRQ_EN2_ADDR, 8'h80);
    @(posedge core_clk);
    fail_req <= 1'b1;
    wait_for(1'b0, 2'h2, 20);
    check("fail src", {6'h0, src}, 8'h02);
    rd(PMCS_IRQ_FLAG2_ADDR);
    check("fail flag", rv & 8'h80, 8'h80);
    check("fail irq", {7'h0, irq}, 8'h01);
    fail_req <= 1'b0;
    cyc(6);
    wr(PMCS_IRQ_FLAG2_ADDR, 8'h00);
    cyc(2);
    check("flag clr", {7'h0, irq}, 8'h00);
  endtask : t_fail

  task automatic t_ec;
    @(posedge core_clk);
    nrst <= 1'b0;
    cfg  <= 8'h44;
    cyc(3);
    nrst <= 1'b1;
    wait_for(1'b1, 2'h0, 10);
    check("ec mon", {7'h0, mon}, 8'h01);
    check("ec state", clk_state(), 8'h0C);
    rd(PMCS_OSC_CTRL_ADDR);
    check("ec ctrl", rv & 8'h8B, 8'h08);
  endtask : t_ec

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset();
    t_start(2150);
    t_src();
    t_modes();
    t_fail();
    t_ec();
    give_verdict();
  end

  initial begin
    #1_500_000;
    err_total++;
    give_verdict();
  end
endmodule : tb

bind pmcs_top pmcs_chk u_chk (.*);
`default_nettype wire
